// *** ctr_tx_regs.sv ***
// Purpose: Transmit-port control register, port select and stamp read-back
// Assumes: Stamp inputs and freeze come from same-clock logic; link clock is sampled
// Notes:   Lane states are decoded here from the control flops and driven out combinationally
// Summary of operation
// - Port 2 and port 3 stamps read as a high and a low byte, port 1 as its low byte only, read only.
// - Stamp bytes sit at 0x2d through 0x31 in order.
// - Port 0 register writes land only while select bit 0 is set.
// - One write updates every enabled port copy at once.
// - Port-specific writes go to the copies picked by the select register at 0x32; reads return port 0 whatever the select.
// - Control bit 6 makes the transmitter send the initial skew calibration before any high-speed data.
// - Lane field 5:4 decodes 00 to four lanes, 01 three, 10 two, 11 one.
// - Field 3:2 gives normal, data-only LP00, or data and clock LP00; 10 is reserved.
// - Continuous clock starts only after the first packet has gone out.
// - The output is driven only while control bit 0 is set.
// - Freeze clears the ready flag and holds stamp bytes stable.
`timescale 1ns/1ps
module ctr_tx_regs
	import ctr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire ctr_req_t    req,
	output logic [7:0]       rdata,
	input  wire logic [15:0] stamp_p1,
	input  wire logic [15:0] stamp_p2,
	input  wire logic [15:0] stamp_p3,
	input  wire logic        stamp_capture,
	input  wire logic        stamp_freeze,
	output logic             stamps_ready_flag,
	input  wire logic        link_clock,
	input  wire logic        packet_sent,
	output ctr_txcfg_t       txcfg,
	output logic             cal_active,
	output logic             hs_allowed,
	output logic             tx_out_en,
	output logic             continuous_clock_on,
	output logic             forced_low_power_data,
	output logic             forced_low_power_clock
);
	logic [7:0]  sel_ff;
	logic [7:0]  ctl_ff;
	logic [15:0] st1_ff;
	logic [15:0] st2_ff;
	logic [15:0] st3_ff;
	logic        ready_ff;
	logic        sent_ff;
	logic        cal_done_ff;
	logic [4:0]  cal_cnt_ff;
	logic        en_d_ff;
	logic        link_sync;
	logic        link_d_ff;
	logic        link_rise;
	logic [7:0]  nxt_rdata;
	logic        port0_wr;

	ctr_sync2 u_link_sync (
		.clock  (clock),
		.resetn (resetn),
		.din    (link_clock),
		.dout   (link_sync)
	);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			link_d_ff <= 1'b0;
		end else begin
			link_d_ff <= link_sync;
		end
	end
	assign link_rise = link_sync & ~link_d_ff;

	// Select register: only bit 0 is implemented
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sel_ff <= CTR_RST_BYTE;
		end else if (req.wr && req.addr == CTR_OFF_PORT_SEL) begin
			sel_ff <= req.wdata & CTR_SEL_MASK;
		end
	end

	// With more copies, each enabled copy would take the same write
	assign port0_wr = req.wr && req.addr == CTR_OFF_LINK_CTL && sel_ff[CTR_SEL_PORT0_BIT];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctl_ff <= CTR_RST_BYTE;
		end else if (port0_wr) begin
			ctl_ff <= req.wdata & CTR_CTL_MASK;
		end
	end

	// Stamps are captured only while not frozen
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st1_ff <= 16'h0000;
			st2_ff <= 16'h0000;
			st3_ff <= 16'h0000;
		end else if (stamp_capture && !stamp_freeze) begin
			st1_ff <= stamp_p1;
			st2_ff <= stamp_p2;
			st3_ff <= stamp_p3;
		end
	end

	// Freeze wins: a capture in a frozen cycle is dropped with it
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ready_ff <= 1'b0;
		end else if (stamp_freeze) begin
			ready_ff <= 1'b0;
		end else if (stamp_capture) begin
			ready_ff <= 1'b1;
		end
	end
	assign stamps_ready_flag = ready_ff;

	always_comb begin
		nxt_rdata = CTR_RST_BYTE;
		case (req.addr)
			CTR_OFF_P1_LO:    nxt_rdata = st1_ff[7:0];
			CTR_OFF_P2_HI:    nxt_rdata = st2_ff[15:8];
			CTR_OFF_P2_LO:    nxt_rdata = st2_ff[7:0];
			CTR_OFF_P3_HI:    nxt_rdata = st3_ff[15:8];
			CTR_OFF_P3_LO:    nxt_rdata = st3_ff[7:0];
			CTR_OFF_PORT_SEL: nxt_rdata = sel_ff;
			CTR_OFF_LINK_CTL: nxt_rdata = ctl_ff;
			default:          nxt_rdata = CTR_RST_BYTE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= CTR_RST_BYTE;
		end else if (req.rd) begin
			rdata <= nxt_rdata;
		end
	end

	// Calibration counted on rising link clock edges; restarts on each output enable
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			en_d_ff     <= 1'b0;
			cal_done_ff <= 1'b0;
			cal_cnt_ff  <= 5'h00;
		end else begin
			en_d_ff <= ctl_ff[CTR_CTL_EN_BIT];
			if (!ctl_ff[CTR_CTL_EN_BIT]) begin
				cal_done_ff <= 1'b0;
				cal_cnt_ff  <= 5'h00;
			end else if (!ctl_ff[CTR_CTL_CAL_BIT]) begin
				cal_done_ff <= 1'b1;
			end else if (!cal_done_ff && link_rise) begin
				if (cal_cnt_ff == 5'(CTR_CAL_CYCLES - 1)) begin
					cal_done_ff <= 1'b1;
				end
				cal_cnt_ff <= cal_cnt_ff + 5'h01;
			end
		end
	end
	assign cal_active = ctl_ff[CTR_CTL_EN_BIT] && en_d_ff && ctl_ff[CTR_CTL_CAL_BIT] && !cal_done_ff;
	assign hs_allowed = ctl_ff[CTR_CTL_EN_BIT] && cal_done_ff;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sent_ff <= 1'b0;
		end else if (!ctl_ff[CTR_CTL_EN_BIT]) begin
			sent_ff <= 1'b0;
		end else if (packet_sent && hs_allowed) begin
			sent_ff <= 1'b1;
		end
	end

	always_comb begin
		txcfg.cal_en     = ctl_ff[CTR_CTL_CAL_BIT];
		txcfg.lanes      = CTR_LANES_MAX - {1'b0, ctl_ff[CTR_CTL_LANE_HI:CTR_CTL_LANE_LO]};
		txcfg.lp_data    = 1'b0;
		txcfg.lp_clock   = 1'b0;
		case (ctl_ff[CTR_CTL_LP_HI:CTR_CTL_LP_LO])
			CTR_LP_DATA: txcfg.lp_data = 1'b1;
			CTR_LP_ALL: begin
				txcfg.lp_data  = 1'b1;
				txcfg.lp_clock = 1'b1;
			end
			default: txcfg.lp_data = 1'b0; // Normal or reserved code
		endcase
		txcfg.cont_clock = ctl_ff[CTR_CTL_CONT_BIT];
		txcfg.out_en     = ctl_ff[CTR_CTL_EN_BIT];
	end

	assign tx_out_en              = ctl_ff[CTR_CTL_EN_BIT];
	assign continuous_clock_on    = tx_out_en && ctl_ff[CTR_CTL_CONT_BIT] && sent_ff;
	assign forced_low_power_data  = txcfg.lp_data;
	assign forced_low_power_clock = txcfg.lp_clock;

	property p_port0_block;
		@(posedge clock) disable iff (!resetn)
		(req.wr && req.addr == CTR_OFF_LINK_CTL && !sel_ff[0]) |=> $stable(ctl_ff);
	endproperty
	a_port0_block: assert property (p_port0_block) else $error("Control written while port 0 not selected");

	property p_port0_write;
		@(posedge clock) disable iff (!resetn)
		(req.wr && req.addr == CTR_OFF_LINK_CTL && sel_ff[0]) |=> ctl_ff == ($past(req.wdata) & 8'h7f);
	endproperty
	a_port0_write: assert property (p_port0_write) else $error("Selected control write not taken");

	property p_sel_route;
		@(posedge clock) disable iff (!resetn)
		(req.rd && req.addr == CTR_OFF_LINK_CTL) |=> rdata == $past(ctl_ff);
	endproperty
	a_sel_route: assert property (p_sel_route) else $error("Control read-back wrong");

	property p_stamp_read;
		@(posedge clock) disable iff (!resetn)
		(req.rd && req.addr == CTR_OFF_P3_HI) |=> rdata == $past(st3_ff[15:8]);
	endproperty
	a_stamp_read: assert property (p_stamp_read) else $error("Port 3 high byte wrong");

	property p_stamp_addr;
		@(posedge clock) disable iff (!resetn)
		(req.rd && req.addr == CTR_OFF_P2_LO) |=> rdata == $past(st2_ff[7:0]);
	endproperty
	a_stamp_addr: assert property (p_stamp_addr) else $error("Port 2 low byte wrong");

	property p_freeze;
		@(posedge clock) disable iff (!resetn)
		stamp_freeze |=> !stamps_ready_flag && $stable(st1_ff) && $stable(st3_ff);
	endproperty
	a_freeze: assert property (p_freeze) else $error("Freeze did not hold stamps");

	property p_cal_first;
		@(posedge clock) disable iff (!resetn)
		(hs_allowed && ctl_ff[6] && !$past(hs_allowed)) |-> $past(cal_cnt_ff) == 5'(CTR_CAL_CYCLES - 1);
	endproperty
	a_cal_first: assert property (p_cal_first) else $error("High speed allowed before calibration");

	property p_lanes;
		@(posedge clock) disable iff (!resetn)
		txcfg.lanes == 3'(4 - ctl_ff[5:4]);
	endproperty
	a_lanes: assert property (p_lanes) else $error("Lane count decode wrong");

	property p_lp;
		@(posedge clock) disable iff (!resetn)
		forced_low_power_clock |-> forced_low_power_data && ctl_ff[3:2] == 2'h3;
	endproperty
	a_lp: assert property (p_lp) else $error("Clock lane forced without code 11");

	property p_cont;
		@(posedge clock) disable iff (!resetn)
		$rose(continuous_clock_on) |-> sent_ff && $past(packet_sent || sent_ff);
	endproperty
	a_cont: assert property (p_cont) else $error("Continuous clock before first packet");

	property p_out;
		@(posedge clock) disable iff (!resetn)
		$changed(tx_out_en) |-> $past(port0_wr) && tx_out_en == $past(req.wdata[0]);
	endproperty
	a_out: assert property (p_out) else $error("Output enable differs from control bit");

	property p_reserved;
		@(posedge clock) disable iff (!resetn)
		ctl_ff[7] == 1'b0 && sel_ff[7:1] == 7'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("Reserved bit set");

	property p_sel_write;
		@(posedge clock) disable iff (!resetn)
		(req.wr && req.addr == CTR_OFF_PORT_SEL) |=> sel_ff == ($past(req.wdata) & CTR_SEL_MASK);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("Select write not taken");

	property p_stamp_wr;
		@(posedge clock) disable iff (!resetn)
		(req.wr && req.addr == CTR_OFF_P2_HI && !stamp_capture) |=> $stable(st2_ff);
	endproperty
	a_stamp_wr: assert property (p_stamp_wr) else $error("Stamp byte took a write");

	property p_capture;
		@(posedge clock) disable iff (!resetn)
		(stamp_capture && !stamp_freeze) |=> stamps_ready_flag && st2_ff == $past(stamp_p2);
	endproperty
	a_capture: assert property (p_capture) else $error("Stamp pair not captured together");

	property p_lp_normal;
		@(posedge clock) disable iff (!resetn)
		(ctl_ff[3:2] == 2'h0 || ctl_ff[3:2] == 2'h2) |-> !forced_low_power_data && !forced_low_power_clock;
	endproperty
	a_lp_normal: assert property (p_lp_normal) else $error("Lanes forced without a forcing code");

	property p_out_off;
		@(posedge clock) disable iff (!resetn)
		!ctl_ff[0] |-> !hs_allowed && !cal_active && !continuous_clock_on;
	endproperty
	a_out_off: assert property (p_out_off) else $error("Link active while output disabled");

	property p_sent;
		@(posedge clock) disable iff (!resetn)
		$rose(sent_ff) |-> $past(packet_sent) && $past(hs_allowed);
	endproperty
	a_sent: assert property (p_sent) else $error("First packet marked without a packet");

	property p_cal_step;
		@(posedge clock) disable iff (!resetn)
		(link_rise && cal_active) |=> cal_cnt_ff == $past(cal_cnt_ff) + 5'h01;
	endproperty
	a_cal_step: assert property (p_cal_step) else $error("Calibration edge not counted");
endmodule

// *** ctr_pkg.sv ***
// Purpose: Shared constants and types for the transmit-port control and stamp read-back bank
// Assumes: Byte-wide register access through a simple internal read/write port
// Notes:   One transmit port copy in this build
package ctr_pkg;
	localparam logic [7:0] CTR_OFF_P1_LO      = 8'h2d;
	localparam logic [7:0] CTR_OFF_P2_HI      = 8'h2e;
	localparam logic [7:0] CTR_OFF_P2_LO      = 8'h2f;
	localparam logic [7:0] CTR_OFF_P3_HI      = 8'h30;
	localparam logic [7:0] CTR_OFF_P3_LO      = 8'h31;
	localparam logic [7:0] CTR_OFF_PORT_SEL   = 8'h32;
	localparam logic [7:0] CTR_OFF_LINK_CTL   = 8'h33;
	localparam logic [7:0] CTR_RST_BYTE       = 8'h00;
	localparam int         CTR_SEL_PORT0_BIT  = 0;
	localparam logic [7:0] CTR_SEL_MASK       = 8'h01;
	localparam int         CTR_CTL_CAL_BIT    = 6;
	localparam int         CTR_CTL_LANE_HI    = 5;
	localparam int         CTR_CTL_LANE_LO    = 4;
	localparam int         CTR_CTL_LP_HI      = 3;
	localparam int         CTR_CTL_LP_LO      = 2;
	localparam int         CTR_CTL_CONT_BIT   = 1;
	localparam int         CTR_CTL_EN_BIT     = 0;
	localparam logic [7:0] CTR_CTL_MASK       = 8'h7f;
	localparam logic [1:0] CTR_LP_NORMAL      = 2'h0;
	localparam logic [1:0] CTR_LP_DATA        = 2'h1;
	localparam logic [1:0] CTR_LP_ALL         = 2'h3;
	localparam logic [2:0] CTR_LANES_MAX      = 3'h4;
	localparam int         CTR_CAL_CYCLES     = 16;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ctr_req_t;

	typedef struct packed {
		logic       cal_en;
		logic [2:0] lanes;
		logic       lp_data;
		logic       lp_clock;
		logic       cont_clock;
		logic       out_en;
	} ctr_txcfg_t;
endpackage

// *** ctr_sync2.sv ***
// Purpose: Two-stage synchroniser for an asynchronous level
// Assumes: Input comes from outside the clock domain
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module ctr_sync2 (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic din,
	output logic      dout
);
	logic meta_ff;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= 1'b0;
			dout    <= 1'b0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule

// *** ctr_far_end.sv ***
// Purpose: Far-end receiver stand-in giving link clock and first-packet marker
// Assumes: Link clock runs only while run is high, 80 ns period
// Notes:   Clock parks low between frames so no stray edges reach the block
`timescale 1ns/1ps
module ctr_far_end (
	input  wire logic clock,
	input  wire logic run,
	input  wire logic hs_allowed,
	output logic      link_clock,
	output logic      packet_sent
);
	logic [2:0] wait_ff;
	// Counter and marker settle at the first clock edge, while the block is still in reset
	initial begin
		link_clock = 1'b0;
		forever #40 link_clock = run ? ~link_clock : 1'b0;
	end
	// First packet some cycles after high speed opens
	always @(posedge clock) begin
		wait_ff <= hs_allowed ? (wait_ff == 3'h7 ? wait_ff : wait_ff + 3'h1) : 3'h0;
		packet_sent <= hs_allowed && wait_ff == 3'h3;
	end
endmodule

// *** ctr_tx_regs_tb.sv ***
// Purpose: Self-checking bench for the transmit control and stamp bank
// Assumes: Forwarding is off throughout, lane rate set for top speed
// Notes:   Only port 0 copy exists
`timescale 1ns/1ps
module ctr_tx_regs_tb;
	import ctr_pkg::*;
	logic        clock, resetn, stamp_capture, stamp_freeze, run, ready, link_clock, packet_sent;
	logic        cal_active, hs_allowed, tx_out_en, cont_on, lp_data, lp_clock;
	logic [15:0] stamp_p1, stamp_p2, stamp_p3;
	logic [7:0]  rdata;
	ctr_req_t    req;
	ctr_txcfg_t  txcfg;
	int          n_mismatch, checks_done, cyc, i;

	ctr_tx_regs dut (.clock(clock), .resetn(resetn), .req(req), .rdata(rdata), .stamp_p1(stamp_p1),
		.stamp_p2(stamp_p2), .stamp_p3(stamp_p3), .stamp_capture(stamp_capture), .stamp_freeze(stamp_freeze),
		.stamps_ready_flag(ready), .link_clock(link_clock), .packet_sent(packet_sent), .txcfg(txcfg),
		.cal_active(cal_active), .hs_allowed(hs_allowed), .tx_out_en(tx_out_en), .continuous_clock_on(cont_on),
		.forced_low_power_data(lp_data), .forced_low_power_clock(lp_clock));
	ctr_far_end far (.clock(clock), .run(run), .hs_allowed(hs_allowed), .link_clock(link_clock),
		.packet_sent(packet_sent));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		req <= '0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		req <= '0;
		@(posedge clock);
		@(negedge clock);
		chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata});
	endtask
	task automatic capture(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		@(posedge clock);
		stamp_p1 <= a;
		stamp_p2 <= b;
		stamp_p3 <= c;
		stamp_capture <= 1'b1;
		@(posedge clock);
		stamp_capture <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic t_reset;
		for (i = 8'h2d; i <= 8'h33; i++) rd_chk(8'(i), CTR_RST_BYTE);
		rd_chk(8'h40, 8'h00);
		chk("lanes", 16'(CTR_LANES_MAX), 16'(txcfg.lanes));
		chk("out_en", 16'h0, 16'(tx_out_en));
	endtask
	task automatic t_select;
		wr(CTR_OFF_LINK_CTL, 8'h01);
		rd_chk(CTR_OFF_LINK_CTL, 8'h00);
		chk("out_en", 16'h0, 16'(tx_out_en));
		wr(CTR_OFF_PORT_SEL, 8'hff);
		rd_chk(CTR_OFF_PORT_SEL, CTR_SEL_MASK);
		wr(CTR_OFF_LINK_CTL, 8'h81);
		rd_chk(CTR_OFF_LINK_CTL, 8'h01);
		chk("out_en", 16'h1, 16'(tx_out_en));
		wr(CTR_OFF_LINK_CTL, 8'h00);
		@(negedge clock);
		chk("out_en", 16'h0, 16'(tx_out_en));
	endtask
	task automatic t_decode;
		for (i = 0; i < 4; i++) begin
			wr(CTR_OFF_LINK_CTL, 8'((i << 4) | (i << 2)));
			@(negedge clock);
			chk("lanes", 16'(4 - i), 16'(txcfg.lanes));
			chk("lp_data", 16'(i == 1 || i == 3), 16'(lp_data));
			chk("lp_clock", 16'(i == 3), 16'(lp_clock));
		end
	endtask
	task automatic t_stamp;
		capture(16'h1a2b, 16'h3c4d, 16'h5e6f);
		chk("ready", 16'h1, 16'(ready));
		rd_chk(CTR_OFF_P1_LO, 8'h2b);
		rd_chk(CTR_OFF_P2_HI, 8'h3c);
		rd_chk(CTR_OFF_P2_LO, 8'h4d);
		rd_chk(CTR_OFF_P3_HI, 8'h5e);
		rd_chk(CTR_OFF_P3_LO, 8'h6f);
		wr(CTR_OFF_P2_HI, 8'hee);
		rd_chk(CTR_OFF_P2_HI, 8'h3c);
		@(posedge clock);
		stamp_freeze <= 1'b1;
		capture(16'h9999, 16'h8888, 16'h7777);
		chk("ready", 16'h0, 16'(ready));
		rd_chk(CTR_OFF_P3_LO, 8'h6f);
		@(posedge clock);
		stamp_freeze <= 1'b0;
	endtask
	task automatic t_cal;
		wr(CTR_OFF_LINK_CTL, 8'h43);
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk("cfg bits", 16'h7, 16'({txcfg.cal_en, txcfg.cont_clock, txcfg.out_en}));
		chk("hs early", 16'h0, 16'(hs_allowed));
		chk("cal", 16'h1, 16'(cal_active));
		chk("out_en", 16'h1, 16'(tx_out_en));
		run <= 1'b1;
		for (i = 0; i < 400 && hs_allowed !== 1'b1; i++) @(posedge clock);
		run <= 1'b0;
		chk("cal long", 16'h1, 16'(i >= 240 && i < 400));
		chk("cont early", 16'h0, 16'(cont_on));
		chk("cal end", 16'h0, 16'(cal_active));
		repeat (10) @(posedge clock);
		chk("cont", 16'h1, 16'(cont_on));
		wr(CTR_OFF_LINK_CTL, 8'h00);
		wr(CTR_OFF_LINK_CTL, 8'h01);
		repeat (8) @(posedge clock);
		chk("hs no cal", 16'h1, 16'(hs_allowed));
		chk("cont off", 16'h0, 16'(cont_on));
	endtask

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Ceiling well above the few hundred cycles the scenarios need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		resetn = 1'b0;
		req = '0;
		run = 1'b0;
		stamp_capture = 1'b0;
		stamp_freeze = 1'b0;
		stamp_p1 = 16'h0000;
		stamp_p2 = 16'h0000;
		stamp_p3 = 16'h0000;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		t_reset();
		t_select();
		t_decode();
		t_stamp();
		t_cal();
		wrap_up();
	end
endmodule
